// *** fdc_pkg.sv ***
// Constants, field layouts and carrier types for the floppy host FIFO and status block.
// Assumes a single 25 MHz clock domain and a plain strobe register port.
//
// Summary of operation
// - All parameter and data bytes pass one 16-byte FIFO with programmable threshold.
// - Pin reset restores single-byte mode; soft reset does too unless hold bit set.
// - Setup-parameters command enables full FIFO with programmed threshold.
// - Each command starts with FIFO off; parameters pass byte by byte.
// - Entering execution phase empties the FIFO of stale bytes.
// - Overrun or underrun ends the command and stops transfers.
// - Underrun on disk write pads the sector with 00 bytes.
// - Disk input status is read-only; basic mode drives bit 7 only.
// - Media-changed bit is inverse of the cable level.
// - Alternate mode shows media-changed bit 7 with inverted polarity.
// - Drive inputs forced inactive force media-changed inactive; others unchanged.
// - Extended mode: bit3 one, bits2:1 rate, bit0 low for 500K or 1M.
// - With powerdown-status enable, bits 6,5,4 show idle, powerdown, idle mask.
// - Alternate mode bit3 mirrors DMA gate, bit2 mirrors precomp-off.
// - Drive specification command can change reported rate bits.
// - Config register write-only; rate bits reset to 1 and 0.
// - Config bit 4 is idle mask only with status enable; ignored in basic mode.
// - Alternate mode bit 2 stored for readback only; hardware reset clears it.
// - Three reset sources; any of them exits powerdown.
// - Entering reset stops all operations and goes idle.
// - Leaving reset clears registers, awaits command, starts drive polling.
// - Pin reset clears all but timing registers, sets output-register reset bit.
// - Rate code 11=1M, 00=500K, 01=300K, 10=250K.
// - Request flag permits one transfer; direction one means host reads.
// - Rate-register reset self clears; output-register reset held, has precedence.
package fdc_pkg;
	// Register indices on the plain port and FIFO depth
	localparam logic [3:0] ADDR_DATA = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_DIS = 4'h2;
	localparam logic [3:0] ADDR_CCR = 4'h3;
	localparam logic [3:0] ADDR_DOR = 4'h4;
	localparam logic [3:0] ADDR_RATE_SEL = 4'h5;
	localparam logic [3:0] ADDR_SETUP = 4'h6;
	localparam logic [3:0] ADDR_CTRL = 4'h7;
	localparam logic [3:0] ADDR_SRB = 4'h8;
	localparam int FIFO_DEPTH = 16;
	localparam logic [4:0] FIFO_DEPTH_C = 5'h10;
	// Field positions
	localparam int RATE_LO_BIT = 0;
	localparam int PRECOMP_OFF_BIT = 2;
	localparam int IDLE_MASK_BIT = 4;
	localparam int DOR_DMA_GATE_BIT = 3;
	localparam int DOR_RESET_N_BIT = 2;
	localparam int RSEL_RESET_BIT = 7;
	localparam int RSEL_PDOWN_BIT = 6;
	localparam int SETUP_HOLD_BIT = 7;
	localparam int SETUP_FULL_BIT = 6;
	localparam int SETUP_NOPOLL_BIT = 5;
	localparam int CTRL_EXEC_BIT = 0;
	localparam int CTRL_DIR_BIT = 1;
	localparam int CTRL_SPEC_BIT = 2;
	// Reset values and rate codes
	localparam logic [1:0] RATE_RESET = 2'h2;
	localparam logic [3:0] THRESH_RESET = 4'h0;
	localparam logic [1:0] RATE_1M = 2'h3;
	localparam logic [1:0] RATE_500K = 2'h0;
	localparam logic [1:0] RATE_300K = 2'h1;
	localparam logic [1:0] RATE_250K = 2'h2;
	// Service budget in ns
	localparam int SERVICE_MARGIN_NS = 1500;

	typedef enum logic [1:0]
	{
		MODE_BASIC = 2'h0,
		MODE_EXTENDED = 2'h1,
		MODE_ALTERNATE = 2'h2
	} host_mode_t;

	typedef enum logic [1:0]
	{
		PH_IDLE = 2'h0,
		PH_COMMAND = 2'h1,
		PH_EXEC = 2'h2,
		PH_RESET = 2'h3
	} phase_t;

	typedef struct packed
	{
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage : fdc_pkg

// *** fdc_host_fifo_status_reset.sv ***
// Host-facing FIFO, disk input status, config/rate control and reset logic.
// Assumes the host and DMA controller keep service timing; inputs are synchronous.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fdc_host_fifo_status_reset
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire fdc_pkg::reg_req_t req,
	output logic [7:0] rdata,
	output logic [7:0] rdata_oe,
	input wire fdc_pkg::host_mode_t host_mode,
	input wire logic powerdown_status_enable,
	input wire logic media_changed_n,
	input wire logic drive_inputs_off,
	input wire logic idle_state,
	input wire logic [1:0] spec_rate,
	input wire logic disk_valid,
	input wire logic [7:0] disk_byte,
	input wire logic disk_take,
	input wire logic disk_write_active,
	output logic [7:0] disk_out,
	output logic disk_pad,
	output logic host_transfer_request,
	output logic transfer_direction,
	output logic dma_request,
	output logic idle_pin,
	output logic powered_down_flag,
	output logic polling_enable,
	output logic core_reset,
	output logic command_abort
);
	// ********************************
	// State
	// ********************************
	typedef struct packed
	{
		logic [15:0][7:0] mem;
		logic [3:0] wp;
		logic [3:0] rp;
		logic [4:0] cnt;
		logic [1:0] rate;
		logic precomp_off;
		logic idle_mask;
		logic srb_idle_mask;
		logic [7:0] digital_output_register;
		logic soft_reset;
		logic hold;
		logic full_fifo;
		logic no_poll;
		logic [3:0] thresh;
		fdc_pkg::phase_t phase;
		logic dir_read;
		logic pdown;
		logic pad;
		logic abort;
		logic [7:0] disk_out;
		logic [7:0] rdata;
		logic [7:0] rdata_oe;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic rst_meta_q;
	logic rst_sync_q;

	// Reset release through two flops
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ********************************
	// Helpers
	// ********************************
	// High-density flag: low only at 500K and 1M
	function automatic logic hd_n(input logic [1:0] r);
		hd_n = !(r == fdc_pkg::RATE_500K || r == fdc_pkg::RATE_1M);
	endfunction : hd_n

	// Status byte for the active host mode
	function automatic logic [7:0] status_byte(input state_t st, input fdc_pkg::host_mode_t m,
		input logic pse, input logic mc_n, input logic off, input logic idl);
		logic chg;
		logic [7:0] b;
		chg = off ? 1'b0 : !mc_n;
		b = 8'h00;
		unique case (m)
			fdc_pkg::MODE_BASIC: b = {chg, 7'h00};
			fdc_pkg::MODE_EXTENDED: b = {chg, idl, st.pdown, st.idle_mask, 1'b1, st.rate, hd_n(st.rate)};
			fdc_pkg::MODE_ALTERNATE: b = {off ? 1'b1 : !chg, idl, st.pdown, st.idle_mask,
				st.digital_output_register[fdc_pkg::DOR_DMA_GATE_BIT], st.precomp_off, st.rate};
			default: b = 8'h00;
		endcase
		if (!pse)
		begin
			b[6:4] = 3'h0;
		end
		status_byte = b;
	endfunction : status_byte

	// ********************************
	// Next state
	// ********************************
	logic pin_like;
	logic soft_any;
	logic fifo_full;
	logic fifo_empty;
	logic push;
	logic pop;
	logic [7:0] push_byte;
	logic want;
	logic req_flag;

	// Request and data-path decode
	always_comb
	begin
		soft_any = !s_q.digital_output_register[fdc_pkg::DOR_RESET_N_BIT] || s_q.soft_reset;
		fifo_full = s_q.cnt == fdc_pkg::FIFO_DEPTH_C;
		fifo_empty = s_q.cnt == 5'h00;
		// Threshold only in full mode during execution phase
		if (s_q.full_fifo && s_q.phase == fdc_pkg::PH_EXEC)
		begin
			want = s_q.dir_read ? (s_q.cnt >= {1'b0, s_q.thresh} + 5'h01)
				: ((fdc_pkg::FIFO_DEPTH_C - s_q.cnt) >= {1'b0, s_q.thresh} + 5'h01);
		end
		else
		begin
			want = s_q.dir_read ? !fifo_empty : fifo_empty;
		end
		req_flag = want && !soft_any && !s_q.abort;
		push = 1'b0;
		pop = 1'b0;
		push_byte = req.wdata;
		pin_like = 1'b0;
		if (!soft_any && !s_q.abort)
		begin
			if (s_q.dir_read)
			begin
				push = disk_valid && !fifo_full;
				push_byte = disk_byte;
				pop = req.rd && req.addr == fdc_pkg::ADDR_DATA && !fifo_empty;
			end
			else
			begin
				push = req.wr && req.addr == fdc_pkg::ADDR_DATA && !fifo_full;
				pop = disk_take && !fifo_empty;
			end
		end
	end

	// Register, FIFO and reset sequencing
	always_comb
	begin
		s_d = s_q;
		s_d.soft_reset = 1'b0;
		s_d.pad = 1'b0;
		if (push)
		begin
			s_d.mem[s_q.wp] = push_byte;
			s_d.wp = s_q.wp + 4'h1;
		end
		if (pop)
		begin
			s_d.disk_out = s_q.mem[s_q.rp];
			s_d.rp = s_q.rp + 4'h1;
		end
		s_d.cnt = s_q.cnt + {4'h0, push} - {4'h0, pop};
		if (s_q.abort && !s_q.dir_read && disk_write_active)
		begin
			s_d.pad = 1'b1;
			s_d.disk_out = 8'h00;
		end
		if (req.wr)
		begin
			unique case (req.addr)
				fdc_pkg::ADDR_CCR:
				begin
					s_d.rate = req.wdata[1:0];
					if (host_mode == fdc_pkg::MODE_ALTERNATE)
					begin
						s_d.precomp_off = req.wdata[fdc_pkg::PRECOMP_OFF_BIT];
					end
					if (powerdown_status_enable && host_mode != fdc_pkg::MODE_BASIC)
					begin
						s_d.idle_mask = req.wdata[fdc_pkg::IDLE_MASK_BIT];
					end
				end
				fdc_pkg::ADDR_SRB: s_d.srb_idle_mask = req.wdata[fdc_pkg::IDLE_MASK_BIT];
				fdc_pkg::ADDR_DOR: s_d.digital_output_register = req.wdata;
				fdc_pkg::ADDR_RATE_SEL:
				begin
					s_d.rate = req.wdata[1:0];
					s_d.soft_reset = req.wdata[fdc_pkg::RSEL_RESET_BIT];
					s_d.pdown = req.wdata[fdc_pkg::RSEL_PDOWN_BIT];
				end
				fdc_pkg::ADDR_SETUP:
				begin
					s_d.hold = req.wdata[fdc_pkg::SETUP_HOLD_BIT];
					s_d.full_fifo = req.wdata[fdc_pkg::SETUP_FULL_BIT];
					s_d.no_poll = req.wdata[fdc_pkg::SETUP_NOPOLL_BIT];
					s_d.thresh = req.wdata[3:0];
				end
				fdc_pkg::ADDR_CTRL:
				begin
					s_d.dir_read = req.wdata[fdc_pkg::CTRL_DIR_BIT];
					if (req.wdata[fdc_pkg::CTRL_EXEC_BIT])
					begin
						s_d.phase = fdc_pkg::PH_EXEC;
						s_d.wp = 4'h0;
						s_d.rp = 4'h0;
						s_d.cnt = 5'h00;
					end
					else
					begin
						s_d.phase = fdc_pkg::PH_COMMAND;
						s_d.abort = 1'b0;
					end
					if (req.wdata[fdc_pkg::CTRL_SPEC_BIT])
					begin
						s_d.rate = spec_rate;
					end
				end
				default: s_d.phase = s_q.phase;
			endcase
		end
		// Overrun or underrun ends the command; set beats a same-cycle control-write clear, a software reset clears it
		if (s_q.phase == fdc_pkg::PH_EXEC && !s_q.abort &&
			((s_q.dir_read && disk_valid && fifo_full) || (!s_q.dir_read && disk_take && fifo_empty)))
		begin
			s_d.abort = 1'b1;
		end
		// Software reset stops everything and goes idle
		if (soft_any)
		begin
			s_d.phase = fdc_pkg::PH_RESET;
			s_d.pdown = 1'b0;
			s_d.abort = 1'b0;
			s_d.wp = 4'h0;
			s_d.rp = 4'h0;
			s_d.cnt = 5'h00;
			if (!s_q.hold)
			begin
				s_d.full_fifo = 1'b0;
				s_d.thresh = fdc_pkg::THRESH_RESET;
			end
		end
		else if (s_q.phase == fdc_pkg::PH_RESET)
		begin
			s_d.phase = fdc_pkg::PH_IDLE;
		end
		// Read data one cycle later
		s_d.rdata = 8'h00;
		s_d.rdata_oe = 8'hFF;
		if (req.rd)
		begin
			unique case (req.addr)
				fdc_pkg::ADDR_DATA: s_d.rdata = pop ? s_q.mem[s_q.rp] : 8'h00;
				fdc_pkg::ADDR_STATUS: s_d.rdata = {req_flag, s_q.dir_read, s_q.phase == fdc_pkg::PH_EXEC,
					s_q.phase != fdc_pkg::PH_IDLE, 4'h0};
				fdc_pkg::ADDR_DIS:
				begin
					s_d.rdata = status_byte(s_q, host_mode, powerdown_status_enable,
						media_changed_n, drive_inputs_off, idle_state);
					s_d.rdata_oe = host_mode == fdc_pkg::MODE_BASIC ? 8'h80 : 8'hFF;
				end
				default: s_d.rdata = 8'h00;
			endcase
		end
	end

	// ********************************
	// Registers
	// ********************************
	// Pin reset clears all but rate, phase and read enables; output-register reset bit comes up active
	always_ff @(posedge ref_clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			s_q <= '0;
			s_q.rate <= fdc_pkg::RATE_RESET;
			s_q.phase <= fdc_pkg::PH_RESET;
			s_q.rdata_oe <= 8'hFF;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	assign rdata = s_q.rdata;
	assign rdata_oe = s_q.rdata_oe;
	assign disk_out = s_q.disk_out;
	assign disk_pad = s_q.pad;
	assign host_transfer_request = req_flag;
	assign transfer_direction = s_q.dir_read;
	assign dma_request = req_flag && s_q.phase == fdc_pkg::PH_EXEC && s_q.digital_output_register[fdc_pkg::DOR_DMA_GATE_BIT];
	// Mask source differs by mode
	assign idle_pin = idle_state && !((host_mode == fdc_pkg::MODE_BASIC) ? s_q.srb_idle_mask : s_q.idle_mask);
	assign powered_down_flag = s_q.pdown;
	assign polling_enable = !s_q.no_poll && s_q.phase == fdc_pkg::PH_IDLE;
	assign core_reset = s_q.phase == fdc_pkg::PH_RESET;
	assign command_abort = s_q.abort;
endmodule : fdc_host_fifo_status_reset
`default_nettype wire

// *** fdc_host_fifo_status_reset_monitor.sv ***
// Checker for the host FIFO, disk input status and reset block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fdc_host_fifo_status_reset_monitor
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire fdc_pkg::reg_req_t req,
	input wire logic [7:0] rdata,
	input wire logic [7:0] rdata_oe,
	input wire fdc_pkg::host_mode_t host_mode,
	input wire logic media_changed_n,
	input wire logic drive_inputs_off,
	input wire logic [7:0] disk_out,
	input wire logic disk_pad,
	input wire logic host_transfer_request,
	input wire logic transfer_direction,
	input wire logic powered_down_flag,
	input wire logic core_reset,
	input wire logic command_abort
);
	// ********
	// Decoded bus cycles
	// ********
	logic dis_rd;
	logic dor_wr;
	logic rst_wr;
	logic ctl_wr;
	logic alt;
	assign dis_rd = req.rd && req.addr == fdc_pkg::ADDR_DIS;
	assign dor_wr = req.wr && req.addr == fdc_pkg::ADDR_DOR;
	assign rst_wr = req.wr && req.addr == fdc_pkg::ADDR_RATE_SEL;
	assign ctl_wr = req.wr && req.addr == fdc_pkg::ADDR_CTRL;
	assign alt = host_mode == fdc_pkg::MODE_ALTERNATE;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ********
	// Status read view, then reset and transfer control
	// ********
	basic_lanes_a: assert property (dis_rd && host_mode == fdc_pkg::MODE_BASIC |=> rdata_oe == 8'h80)
		else $error("basic status lanes wrong");
	read_stands_a: assert property (!req.rd |=> rdata == 8'h00)
		else $error("read data outside read slot");
	media_level_a: assert property (dis_rd && !alt && !drive_inputs_off |=> rdata[7] == !$past(media_changed_n))
		else $error("media bit not inverse of cable");
	media_alt_a: assert property (dis_rd && alt && !drive_inputs_off |=> rdata[7] == $past(media_changed_n))
		else $error("alternate media polarity wrong");
	media_forced_a: assert property (dis_rd && !alt && drive_inputs_off |=> !rdata[7])
		else $error("media bit not forced inactive");
	ext_rate_a: assert property (dis_rd && host_mode == fdc_pkg::MODE_EXTENDED |=> rdata[3] && rdata[0] == ^rdata[2:1])
		else $error("extended rate view wrong");
	dor_hold_a: assert property (dor_wr && !req.wdata[2] |=> ##1 core_reset)
		else $error("held reset not applied");
	dor_release_a: assert property (dor_wr && req.wdata[2] |=> ##1 !core_reset)
		else $error("reset not left after release");
	soft_reset_a: assert property (rst_wr && req.wdata[7] |=> ##1 core_reset)
		else $error("self clearing reset missing");
	pd_exit_a: assert property (rst_wr && req.wdata[7] && !req.wdata[6] |=> ##1 !powered_down_flag)
		else $error("reset left powerdown set");
	pad_zero_a: assert property (disk_pad |-> disk_out == 8'h00)
		else $error("pad byte not zero");
	dir_follow_a: assert property (ctl_wr && !core_reset |=> transfer_direction == $past(req.wdata[1]))
		else $error("direction flag not taken");
	// Main scenarios reached
	cover property (disk_pad);
	cover property (command_abort);
	cover property (host_transfer_request && transfer_direction);
endmodule : fdc_host_fifo_status_reset_monitor
bind fdc_host_fifo_status_reset fdc_host_fifo_status_reset_monitor mon (.ref_clk, .rst_n, .req, .rdata, .rdata_oe,
	.host_mode, .media_changed_n, .drive_inputs_off, .disk_out, .disk_pad, .host_transfer_request,
	.transfer_direction, .powered_down_flag, .core_reset, .command_abort);
`default_nettype wire

// *** host_dma_model.sv ***
// Host and DMA partner: drains the data port one byte per grant.
// Assumes the bench routes its request onto the block's register port.
`timescale 1ns/1ps
`default_nettype none
module host_dma_model
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic [1:0] gap,
	input wire logic hreq,
	input wire logic dir,
	input wire logic [7:0] rdata,
	output var fdc_pkg::reg_req_t mreq,
	output logic [7:0] got,
	output logic [4:0] cnt
);
	logic pend;
	logic [1:0] hold;
	// One read at a time; gap makes it a slow master
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mreq <= '0;
			pend <= 1'b0;
			got <= 8'h00;
			cnt <= 5'h00;
			hold <= 2'h0;
		end
		else if (mreq.rd)
		begin
			mreq.rd <= 1'b0;
			pend <= 1'b1;
		end
		else if (pend)
		begin
			got <= rdata;
			cnt <= cnt + 5'h01;
			pend <= 1'b0;
			hold <= gap;
		end
		else if (hold != 2'h0)
			hold <= hold - 2'h1;
		else if (en && hreq && dir)
			mreq <= '{fdc_pkg::ADDR_DATA, 8'h00, 1'b0, 1'b1};
	end
endmodule : host_dma_model
`default_nettype wire

// *** fdc_host_fifo_status_reset_bench.sv ***
// Self-checking bench for the host FIFO, status and reset block.
// Assumes the checker is bound and the partner model drives data reads.
`timescale 1ns/1ps
`default_nettype none
module fdc_host_fifo_status_reset_bench;
	typedef struct packed {fdc_pkg::host_mode_t m; logic n; logic f; logic p; logic [7:0] e; logic [7:0] k;} row_t;
	logic ref_clk = 0;
	logic rst_n = 0;
	logic media_changed_n = 0, drive_inputs_off = 0, powerdown_status_enable = 0, idle_state = 1;
	logic disk_valid = 0, disk_take = 0, disk_write_active = 0, dma_on = 0;
	logic [1:0] spec_rate = 2'h1;
	logic [7:0] disk_byte = 8'h00, rdata, rdata_oe, disk_out, got, v;
	logic disk_pad, host_transfer_request, transfer_direction, powered_down_flag, core_reset, command_abort;
	logic dma_request, idle_pin, polling_enable;
	logic [4:0] cnt;
	int err_count = 0, num_checks = 0;
	fdc_pkg::host_mode_t host_mode = fdc_pkg::MODE_BASIC;
	fdc_pkg::reg_req_t bq = '0, mreq, req;
	row_t rows [6] = '{'{fdc_pkg::MODE_BASIC, 0, 0, 0, 8'h80, 8'h80}, '{fdc_pkg::MODE_BASIC, 1, 0, 0, 8'h00, 8'h80},
		'{fdc_pkg::MODE_BASIC, 0, 1, 0, 8'h00, 8'h80}, '{fdc_pkg::MODE_EXTENDED, 0, 0, 0, 8'h8D, 8'h8F},
		'{fdc_pkg::MODE_EXTENDED, 0, 1, 1, 8'h4D, 8'hEF}, '{fdc_pkg::MODE_ALTERNATE, 0, 0, 0, 8'h02, 8'h8F}};
	assign req = dma_on ? mreq : bq;
	always #20 ref_clk = ~ref_clk;
	fdc_host_fifo_status_reset dut (.ref_clk, .rst_n, .req, .rdata, .rdata_oe, .host_mode, .powerdown_status_enable,
		.media_changed_n, .drive_inputs_off, .idle_state, .spec_rate, .disk_valid, .disk_byte, .disk_take,
		.disk_write_active, .disk_out, .disk_pad, .host_transfer_request, .transfer_direction, .dma_request,
		.idle_pin, .powered_down_flag, .polling_enable, .core_reset, .command_abort);
	host_dma_model host (.ref_clk, .rst_n, .en(dma_on), .gap(2'h1), .hreq(host_transfer_request),
		.dir(transfer_direction), .rdata, .mreq, .got, .cnt);
	// ********
	// Bus, stream and checking tasks
	// ********
	task chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bq <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		bq.wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a);
		@(posedge ref_clk);
		bq <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		bq.rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd
	task push(input logic [7:0] d);
		@(posedge ref_clk);
		disk_valid <= 1'b1;
		disk_byte <= d;
		@(posedge ref_clk);
		disk_valid <= 1'b0;
		#1;
	endtask : push
	// Bounded wait; a hung flag shows up as a mismatch later
	task automatic wt(ref logic s, input logic e);
		for (int i = 0; i < 8 && s !== e; i++)
		begin
			@(posedge ref_clk);
			#1;
		end
	endtask : wt
	task reset_seq();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask : reset_seq
	task final_report();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	// Watchdog well beyond the expected few hundred cycles
	initial
	begin
		#100000;
		err_count++;
		final_report();
	end
	// ********
	// Table of status views, then awkward cases
	// ********
	initial
	begin
		reset_seq();
		wr(fdc_pkg::ADDR_DOR, 8'h04);
		wt(polling_enable, 1'b1);
		chk(8'(polling_enable), 8'h01);
		foreach (rows[i])
		begin
			@(posedge ref_clk);
			host_mode <= rows[i].m;
			media_changed_n <= rows[i].n;
			drive_inputs_off <= rows[i].f;
			powerdown_status_enable <= rows[i].p;
			rd(fdc_pkg::ADDR_DIS);
			chk(v & rows[i].k, rows[i].e);
			if (rows[i].m == fdc_pkg::MODE_BASIC)
				chk(rdata_oe, 8'h80);
		end
		host_mode <= fdc_pkg::MODE_EXTENDED;
		for (int r = 0; r < 4; r++)
		begin
			wr(fdc_pkg::ADDR_CCR, 8'(r));
			rd(fdc_pkg::ADDR_DIS);
			chk(v & 8'h07, {5'h00, 2'(r), ^(2'(r))});
		end
		rd(4'hF);
		wr(fdc_pkg::ADDR_CTRL, 8'h04);
		rd(fdc_pkg::ADDR_DIS);
		chk(v & 8'h06, 8'h02);
		host_mode <= fdc_pkg::MODE_ALTERNATE;
		wr(fdc_pkg::ADDR_DOR, 8'h0C);
		wr(fdc_pkg::ADDR_CCR, 8'h04);
		rd(fdc_pkg::ADDR_DIS);
		chk(v & 8'h0C, 8'h0C);
		// Full mode, threshold of four bytes, host reads
		wr(fdc_pkg::ADDR_SETUP, 8'h43);
		wr(fdc_pkg::ADDR_CTRL, 8'h03);
		for (int i = 1; i < 4; i++)
			push(8'(i));
		chk(8'(host_transfer_request), 8'h00);
		push(8'h04);
		chk(8'(host_transfer_request), 8'h01);
		chk(8'(dma_request), 8'h01);
		dma_on <= 1'b1;
		for (int i = 0; i < 20 && cnt == 5'h00; i++)
		begin
			@(posedge ref_clk);
			#1;
		end
		@(posedge ref_clk);
		dma_on <= 1'b0;
		#1;
		chk(got, 8'h01);
		chk(8'(host_transfer_request), 8'h00);
		for (int i = 0; i < 14; i++)
			push(8'h10);
		wt(command_abort, 1'b1);
		chk(8'(command_abort), 8'h01);
		// Write direction on a fresh execution phase: leftovers must be gone
		wr(fdc_pkg::ADDR_CTRL, 8'h00);
		wr(fdc_pkg::ADDR_CTRL, 8'h01);
		#1;
		chk({7'h00, transfer_direction}, 8'h00);
		chk(8'(host_transfer_request), 8'h01);
		@(posedge ref_clk);
		disk_write_active <= 1'b1;
		disk_take <= 1'b1;
		@(posedge ref_clk);
		disk_take <= 1'b0;
		#1;
		wt(disk_pad, 1'b1);
		chk({disk_pad, disk_out[6:0]}, 8'h80);
		wt(command_abort, 1'b1);
		chk(8'(command_abort), 8'h01);
		disk_write_active <= 1'b0;
		// Self clearing soft reset returns to single byte requests
		wr(fdc_pkg::ADDR_RATE_SEL, 8'h40);
		#1;
		chk(8'(powered_down_flag), 8'h01);
		wr(fdc_pkg::ADDR_RATE_SEL, 8'h80);
		wt(core_reset, 1'b1);
		chk(8'(core_reset), 8'h01);
		chk(8'(powered_down_flag), 8'h00);
		wt(core_reset, 1'b0);
		rd(fdc_pkg::ADDR_DIS);
		chk(v & 8'h04, 8'h04);
		wr(fdc_pkg::ADDR_CTRL, 8'h00);
		wr(fdc_pkg::ADDR_CTRL, 8'h03);
		push(8'h5A);
		chk(8'(host_transfer_request), 8'h01);
		wr(fdc_pkg::ADDR_DOR, 8'h00);
		wt(core_reset, 1'b1);
		chk(8'(core_reset), 8'h01);
		wr(fdc_pkg::ADDR_DOR, 8'h04);
		// Pin reset in mid-run restores the hardware defaults
		@(posedge ref_clk);
		rst_n <= 1'b0;
		#1;
		chk(8'(core_reset), 8'h01);
		reset_seq();
		rd(fdc_pkg::ADDR_DIS);
		chk(v & 8'h07, 8'h02);
		// Idle mask in the config register counts only with status enable
		chk(8'(idle_pin), 8'h01);
		wr(fdc_pkg::ADDR_CCR, 8'h10);
		#1;
		chk(8'(idle_pin), 8'h01);
		powerdown_status_enable <= 1'b1;
		wr(fdc_pkg::ADDR_CCR, 8'h10);
		#1;
		chk(8'(idle_pin), 8'h00);
		final_report();
	end
endmodule : fdc_host_fifo_status_reset_bench
`default_nettype wire
